// *** logic/ccr_pkg.sv ***
// comparator control register package: offsets, fields, reset values
// assumes an APB slave with one aligned 32-bit word per register index
package ccr_pkg;

	// ----------------------------------------
	// register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam int IDX_W = 4;
	localparam logic [3:0] IDX_CTL_A = 4'h0;
	localparam logic [3:0] IDX_CTL_B = 4'h1;
	localparam logic [3:0] IDX_MUX = 4'h2;
	localparam logic [3:0] IDX_REF = 4'h5;
	localparam logic [3:0] IDX_INT = 4'h6;
	localparam logic [3:0] IDX_STATUS = 4'h7;
	localparam logic [3:0] IDX_EV_STAT = 4'h8;
	localparam logic [3:0] IDX_EV_CLR = 4'h9;
	localparam logic [3:0] IDX_EV_EN = 4'hA;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int B_STBY_RUN = 7;
	localparam int B_PAD_EN = 6;
	localparam int B_POWER = 3;
	localparam int B_HYST = 1;
	localparam int B_ENABLE = 0;
	localparam int B_PARTNER = 0;
	localparam int B_INVERT = 7;
	localparam int B_PRESET = 6;
	localparam int B_POS = 3;
	localparam int B_NEG = 0;
	localparam int B_TRIG = 4;
	localparam int B_IRQ_EN = 0;
	localparam int B_IRQ_FLAG = 0;
	localparam int EV_MATCH = 0;
	localparam int EV_READY = 1;

	// ----------------------------------------
	// reset values and writable masks
	// ----------------------------------------
	localparam logic [7:0] RST_CTL_A = 8'h00;
	localparam logic [7:0] RST_CTL_B = 8'h00;
	localparam logic [7:0] RST_MUX = 8'h00;
	localparam logic [7:0] RST_REF = 8'hFF;
	localparam logic [7:0] RST_INT = 8'h00;
	localparam logic [1:0] RST_EV = 2'h0;
	localparam logic [7:0] MASK_CTL_A = 8'hDF;
	localparam logic [7:0] MASK_CTL_B = 8'h03;
	localparam logic [7:0] MASK_INT = 8'h31;

	// ----------------------------------------
	// codes
	// ----------------------------------------
	localparam logic [1:0] POWER_RSVD = 2'h3;
	localparam logic [1:0] PARTNER_OFF = 2'h0;
	localparam logic [1:0] PARTNER_RSVD = 2'h3;
	localparam logic [2:0] POS_MAX = 3'h3;
	localparam logic [2:0] NEG_MAX = 3'h3;
	localparam logic [1:0] TRIG_BOTH = 2'h0;
	localparam logic [1:0] TRIG_FALL = 2'h2;
	localparam logic [1:0] TRIG_RISE = 2'h3;
	localparam logic [1:0] WIN_ABOVE = 2'h0;
	localparam logic [1:0] WIN_INSIDE = 2'h1;
	localparam logic [1:0] WIN_BELOW = 2'h2;
	localparam logic [1:0] WIN_OUTSIDE = 2'h3;
	localparam int SYNC_STAGES = 3;

	typedef struct packed {
		logic enable;
		logic [1:0] power;
		logic [1:0] hyst;
		logic [2:0] posSel;
		logic [2:0] negSel;
		logic [7:0] refCode;
		logic [1:0] partner;
	} ccr_analog_t;

endpackage

// *** logic/ccr_regs.sv ***
// comparator control registers with APB slave, sync and interrupt logic
// assumes async compare, partner and ready levels from the analog core
//
// Our own choice: register access over APB.
`timescale 1ns/10ps

module ccr_regs #(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic compareRaw,
	input wire logic partnerRaw,
	input wire logic coreReadyRaw,
	input wire logic sleepStandby,
	output ccr_pkg::ccr_analog_t analogCfg,
	output logic compareOut,
	output logic outPin,
	output logic outPinOe,
	output logic irq
);
	import ccr_pkg::*;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [7:0] ctlA;
	logic [7:0] ctlB;
	logic [7:0] muxCtl;
	logic [7:0] refLevel;
	logic [7:0] intCtl;
	logic [1:0] evStatus;
	logic [1:0] evEnable;
	logic irqFlag;
	logic cmpStateReg;
	logic [1:0] winPosReg;
	logic [7:0] rdMux;
	logic mapped;
	logic wrEn;
	logic [IDX_W-1:0] idx;
	logic [2:0] asyncIn;
	logic [2:0] s1;
	logic [2:0] s2;
	logic [2:0] s3;
	logic [2:0] held;
	logic [2:0] stable;
	logic active;
	logic readyOk;
	logic rdyPrev;
	logic next_out;
	logic outPrev;
	logic windowOn;
	logic [1:0] winPos;
	logic winMatch;
	logic winMatchReg;
	logic matchPrev;
	logic edgeHit;
	logic setFlag;
	logic statusClr;
	logic [1:0] evSet;
	logic [1:0] evClr;

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	assign idx = paddr[IDX_W+1:2];
	assign wrEn = psel & penable & pready & pwrite & mapped;

	always_comb begin
		rdMux = 8'h00;
		mapped = 1'b1;
		case (idx)
			IDX_CTL_A: rdMux = ctlA;
			IDX_CTL_B: rdMux = ctlB;
			IDX_MUX: rdMux = muxCtl;
			IDX_REF: rdMux = refLevel;
			IDX_INT: rdMux = intCtl;
			IDX_STATUS: rdMux = {winPosReg, 1'h0, cmpStateReg, 3'h0, irqFlag};
			IDX_EV_STAT: rdMux = {6'h00, evStatus};
			IDX_EV_CLR: rdMux = 8'h00;
			IDX_EV_EN: rdMux = {6'h00, evEnable};
			default: mapped = 1'b0;
		endcase
		// upper address bits and byte offset must be zero
		if (paddr[ADDR_W-1:IDX_W+2] != '0 || paddr[1:0] != 2'h0) begin
			mapped = 1'b0;
		end
		if (!mapped) begin
			rdMux = 8'h00;
		end
	end

	// no wait state: data is captured in setup so prdata is a flop
	always_ff @(posedge clk) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pready <= 1'b1;
			prdata <= {24'h00_0000, rdMux};
			pslverr <= ~mapped;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			ctlA <= RST_CTL_A;
		end else if (wrEn && idx == IDX_CTL_A) begin
			ctlA <= pwdata[7:0] & MASK_CTL_A;
			// reserved profile code leaves the old profile in place
			if (pwdata[B_POWER+:2] == POWER_RSVD) begin
				ctlA[B_POWER+:2] <= ctlA[B_POWER+:2];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ctlB <= RST_CTL_B;
		end else if (wrEn && idx == IDX_CTL_B) begin
			if (pwdata[B_PARTNER+:2] != PARTNER_RSVD) begin
				ctlB <= pwdata[7:0] & MASK_CTL_B;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			muxCtl <= RST_MUX;
		end else if (wrEn && idx == IDX_MUX) begin
			muxCtl[B_INVERT] <= pwdata[B_INVERT];
			muxCtl[B_PRESET] <= pwdata[B_PRESET];
			if (pwdata[B_POS+:3] <= POS_MAX) begin
				muxCtl[B_POS+:3] <= pwdata[B_POS+:3];
			end
			if (pwdata[B_NEG+:3] <= NEG_MAX) begin
				muxCtl[B_NEG+:3] <= pwdata[B_NEG+:3];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			refLevel <= RST_REF;
		end else if (wrEn && idx == IDX_REF) begin
			refLevel <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			intCtl <= RST_INT;
		end else if (wrEn && idx == IDX_INT) begin
			intCtl <= pwdata[7:0] & MASK_INT;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			evEnable <= RST_EV;
		end else if (wrEn && idx == IDX_EV_EN) begin
			evEnable <= pwdata[1:0];
		end
	end

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	assign asyncIn = {coreReadyRaw, partnerRaw, compareRaw};

	// a change counts only once stages two and three agree
	for (genvar g = 0; g < SYNC_STAGES; g++) begin : gSync
		assign stable[g] = (s2[g] == s3[g]) ? s3[g] : held[g];
		always_ff @(posedge clk) begin
			if (rst) begin
				s1[g] <= 1'b0;
				s2[g] <= 1'b0;
				s3[g] <= 1'b0;
				held[g] <= 1'b0;
			end else begin
				s1[g] <= asyncIn[g];
				s2[g] <= s1[g];
				s3[g] <= s2[g];
				held[g] <= stable[g];
			end
		end
	end

	// ----------------------------------------
	// output forming and window logic
	// ----------------------------------------
	assign active = ctlA[B_ENABLE] & ~(sleepStandby & ~ctlA[B_STBY_RUN]);
	assign readyOk = active & stable[2];
	assign next_out = readyOk ? (stable[0] ^ muxCtl[B_INVERT]) : muxCtl[B_PRESET];
	assign windowOn = ctlB[B_PARTNER+:2] != PARTNER_OFF;

	// own result above upper limit, partner result above lower limit
	always_comb begin
		winPos = WIN_BELOW;
		if (stable[0]) begin
			winPos = WIN_ABOVE;
		end else if (stable[1]) begin
			winPos = WIN_INSIDE;
		end
		case (intCtl[B_TRIG+:2])
			WIN_ABOVE: winMatch = readyOk & (winPos == WIN_ABOVE);
			WIN_INSIDE: winMatch = readyOk & (winPos == WIN_INSIDE);
			WIN_BELOW: winMatch = readyOk & (winPos == WIN_BELOW);
			WIN_OUTSIDE: winMatch = readyOk & (winPos != WIN_INSIDE);
			default: winMatch = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			compareOut <= 1'b0;
			outPin <= 1'b0;
			outPinOe <= 1'b0;
			outPrev <= 1'b0;
			winMatchReg <= 1'b0;
			matchPrev <= 1'b0;
			rdyPrev <= 1'b0;
		end else begin
			compareOut <= next_out;
			outPin <= next_out;
			outPinOe <= ctlA[B_PAD_EN];
			outPrev <= compareOut;
			winMatchReg <= winMatch;
			matchPrev <= winMatchReg;
			rdyPrev <= readyOk;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			analogCfg <= '0;
		end else begin
			analogCfg.enable <= active;
			analogCfg.power <= ctlA[B_POWER+:2];
			analogCfg.hyst <= ctlA[B_HYST+:2];
			analogCfg.posSel <= muxCtl[B_POS+:3];
			analogCfg.negSel <= muxCtl[B_NEG+:3];
			analogCfg.refCode <= refLevel;
			analogCfg.partner <= ctlB[B_PARTNER+:2];
		end
	end

	// ----------------------------------------
	// flags and interrupt
	// ----------------------------------------
	always_comb begin
		case (intCtl[B_TRIG+:2])
			TRIG_BOTH: edgeHit = compareOut ^ outPrev;
			TRIG_FALL: edgeHit = ~compareOut & outPrev;
			TRIG_RISE: edgeHit = compareOut & ~outPrev;
			default: edgeHit = 1'b0;
		endcase
	end

	// the clock is gone in standby, so nothing is allowed to set
	assign setFlag = ~sleepStandby & (windowOn ? (winMatchReg & ~matchPrev) : edgeHit);
	assign statusClr = wrEn & (idx == IDX_STATUS) & pwdata[B_IRQ_FLAG];
	assign evSet = {~sleepStandby & readyOk & ~rdyPrev, setFlag};
	assign evClr = (wrEn && idx == IDX_EV_CLR) ? pwdata[1:0] : 2'h0;

	always_ff @(posedge clk) begin
		if (rst) begin
			irqFlag <= 1'b0;
		end else begin
			irqFlag <= setFlag | (irqFlag & ~statusClr);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			evStatus <= RST_EV;
		end else begin
			evStatus <= evSet | (evStatus & ~evClr);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cmpStateReg <= 1'b0;
			winPosReg <= WIN_ABOVE;
		end else if (!sleepStandby) begin
			cmpStateReg <= windowOn ? winMatch : next_out;
			winPosReg <= windowOn ? winPos : WIN_ABOVE;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= (irqFlag & intCtl[B_IRQ_EN]) | (|(evStatus & evEnable));
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_raw_steady;
		$stable(compareRaw) [*4];
	endsequence

	sequence s_ctl_write(logic [3:0] i);
		wrEn && idx == i;
	endsequence

	property p_reset_vals;
		@(posedge clk) disable iff (1'b0) rst |=> ctlA == RST_CTL_A && refLevel == RST_REF;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");
	property p_halt;
		sleepStandby && !ctlA[B_STBY_RUN] |=> !analogCfg.enable;
	endproperty
	a_halt: assert property (p_halt) else $error("not halted in standby");
	property p_frozen;
		sleepStandby |=> !$rose(irqFlag) && $stable(cmpStateReg);
	endproperty
	a_frozen: assert property (p_frozen) else $error("flag moved in standby");
	property p_pad;
		1'b1 |=> outPinOe == $past(ctlA[B_PAD_EN]) && outPin == compareOut;
	endproperty
	a_pad: assert property (p_pad) else $error("pad differs from output");
	property p_power_rsvd;
		s_ctl_write(IDX_CTL_A) and pwdata[B_POWER+:2] == POWER_RSVD
			|=> $stable(ctlA[B_POWER+:2]);
	endproperty
	a_power_rsvd: assert property (p_power_rsvd) else $error("reserved profile taken");
	property p_partner_rsvd;
		s_ctl_write(IDX_CTL_B) and pwdata[B_PARTNER+:2] == PARTNER_RSVD |=> $stable(ctlB);
	endproperty
	a_partner_rsvd: assert property (p_partner_rsvd) else $error("reserved partner taken");
	property p_preset;
		!readyOk |=> compareOut == $past(muxCtl[B_PRESET]);
	endproperty
	a_preset: assert property (p_preset) else $error("preset not shown");
	property p_invert;
		s_raw_steady ##0 readyOk && $stable(muxCtl) |=>
			compareOut == ($past(compareRaw, 4) ^ $past(muxCtl[B_INVERT]));
	endproperty
	a_invert: assert property (p_invert) else $error("output not xor invert");
	property p_sync;
		s_raw_steady |-> stable[0] == $past(compareRaw, 3);
	endproperty
	a_sync: assert property (p_sync) else $error("sync delay wrong");
	property p_rise;
		!windowOn && intCtl[B_TRIG+:2] == TRIG_RISE && compareOut && !outPrev
			&& !sleepStandby |=> irqFlag;
	endproperty
	a_rise: assert property (p_rise) else $error("rising edge missed");
	property p_clear;
		statusClr && !setFlag |=> !irqFlag ##1 (!irqFlag || $past(setFlag));
	endproperty
	a_clear: assert property (p_clear) else $error("flag clear failed");
	property p_irq;
		irqFlag && intCtl[B_IRQ_EN] |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule

// *** tb/tb.sv ***
// testbench for the comparator control register block, driven over APB
// assumes the design answers every APB access with pready within 20 clocks of the access phase
`timescale 1ns/10ps

module tb;
	import ccr_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk;
	logic rst;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic compareRaw;
	logic partnerRaw;
	logic coreReadyRaw;
	logic sleepStandby;
	ccr_pkg::ccr_analog_t analogCfg;
	logic compareOut;
	logic outPin;
	logic outPinOe;
	logic irq;
	logic [31:0] rd;
	logic err;
	int n_mismatch = 0;
	int compares = 0;

	ccr_regs #(.ADDR_W(8)) i_ccr_regs (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .compareRaw(compareRaw), .partnerRaw(partnerRaw),
		.coreReadyRaw(coreReadyRaw), .sleepStandby(sleepStandby), .analogCfg(analogCfg),
		.compareOut(compareOut), .outPin(outPin), .outPinOe(outPinOe), .irq(irq));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task end_sim;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one full APB transfer; a hung slave ends the run
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_mismatch++;
			end_sim;
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	task rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 8'h00);
		chk(name, rd, exp);
	endtask

	// compare path needs four edges; the flag takes a fifth and the irq register the sixth
	task settle;
		repeat (6) @(posedge clk);
	endtask

	task clr;
		wr(8'h1C, 8'h01);
		repeat (2) @(posedge clk);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		rdchk("control_a", 8'h00, 32'h00000000);
		rdchk("control_b", 8'h04, 32'h00000000);
		rdchk("input_mux_control", 8'h08, 32'h00000000);
		rdchk("reference_level", 8'h14, 32'h000000FF);
		rdchk("interrupt_control", 8'h18, 32'h00000000);
		rdchk("compare_status", 8'h1C, 32'h00000000);
		apb(1'b0, 8'h0C, 8'h00);
		chk("unmapped err", {31'h0, err}, 32'h1);
		chk("unmapped data", rd, 32'h0);
	endtask

	task t_fields;
		wr(8'h00, 8'hD7);
		wr(8'h04, 8'h02);
		wr(8'h08, 8'h1B);
		wr(8'h14, 8'h80);
		rdchk("control_a", 8'h00, 32'h000000D7);
		rdchk("control_b", 8'h04, 32'h00000002);
		rdchk("input_mux_control", 8'h08, 32'h0000001B);
		chk("analogCfg", {11'h0, analogCfg}, {11'h0, 1'b1, 2'h2, 2'h3, 3'h3, 3'h3, 8'h80, 2'h2});
		chk("outPinOe on", {31'h0, outPinOe}, 32'h1);
		wr(8'h00, 8'h19);
		rdchk("control_a profile3", 8'h00, 32'h00000011);
		wr(8'h04, 8'h03);
		rdchk("control_b partner3", 8'h04, 32'h00000002);
		wr(8'h04, 8'h01);
		rdchk("control_b partner1", 8'h04, 32'h00000001);
		wr(8'h08, 8'h2A);
		rdchk("mux pos5", 8'h08, 32'h0000001A);
		wr(8'h08, 8'h1C);
		rdchk("mux neg4", 8'h08, 32'h0000001A);
		chk("outPinOe off", {31'h0, outPinOe}, 32'h0);
		wr(8'h04, 8'h00);
	endtask

	task t_output;
		wr(8'h08, 8'h40);
		settle;
		chk("preset out", {31'h0, compareOut}, 32'h1);
		chk("preset pin", {31'h0, outPin}, 32'h1);
		coreReadyRaw <= 1'b1;
		settle;
		chk("ready low", {31'h0, compareOut}, 32'h0);
		compareRaw <= 1'b1;
		settle;
		chk("ready high", {31'h0, outPin}, 32'h1);
		wr(8'h08, 8'h80);
		settle;
		chk("inverted", {31'h0, compareOut}, 32'h0);
		apb(1'b0, 8'h1C, 8'h00);
		chk("state bit", {31'h0, rd[4]}, 32'h0);
		wr(8'h08, 8'h00);
		compareRaw <= 1'b0;
		settle;
	endtask

	task t_trigger;
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			wr(8'h18, {2'b00, c, 4'h1});
			clr;
			compareRaw <= 1'b1;
			settle;
			apb(1'b0, 8'h1C, 8'h00);
			chk("rise flag", {31'h0, rd[0]}, {31'h0, c == 2'h0 || c == 2'h3});
			chk("rise irq", {31'h0, irq}, {31'h0, c == 2'h0 || c == 2'h3});
			clr;
			chk("irq cleared", {31'h0, irq}, 32'h0);
			compareRaw <= 1'b0;
			settle;
			apb(1'b0, 8'h1C, 8'h00);
			chk("fall flag", {31'h0, rd[0]}, {31'h0, c == 2'h0 || c == 2'h2});
			clr;
		end
		wr(8'h18, 8'h30);
		compareRaw <= 1'b1;
		settle;
		apb(1'b0, 8'h1C, 8'h00);
		chk("masked flag", {31'h0, rd[0]}, 32'h1);
		chk("masked irq", {31'h0, irq}, 32'h0);
		apb(1'b0, 8'h20, 8'h00);
		chk("event match", {31'h0, rd[0]}, 32'h1);
		wr(8'h24, 8'h03);
		rdchk("event cleared", 8'h20, 32'h0);
		clr;
		compareRaw <= 1'b0;
		settle;
		clr;
	endtask

	// standby without run halts the output; with run, flags still freeze
	task t_standby;
		wr(8'h18, 8'h01);
		sleepStandby <= 1'b1;
		compareRaw <= 1'b1;
		settle;
		chk("halted out", {31'h0, compareOut}, 32'h0);
		chk("halted irq", {31'h0, irq}, 32'h0);
		sleepStandby <= 1'b0;
		settle;
		chk("woken irq", {31'h0, irq}, 32'h1);
		wr(8'h00, 8'h81);
		// preset high, so a halted output could not pass for a running one
		wr(8'h08, 8'h40);
		clr;
		sleepStandby <= 1'b1;
		compareRaw <= 1'b0;
		settle;
		chk("run out", {31'h0, compareOut}, 32'h0);
		apb(1'b0, 8'h1C, 8'h00);
		chk("frozen flag", {31'h0, rd[0]}, 32'h0);
		sleepStandby <= 1'b0;
		settle;
		clr;
	endtask

	task t_window;
		wr(8'h04, 8'h01);
		wr(8'h18, 8'h11);
		compareRaw <= 1'b1;
		partnerRaw <= 1'b1;
		settle;
		clr;
		compareRaw <= 1'b0;
		settle;
		apb(1'b0, 8'h1C, 8'h00);
		chk("window status", {24'h0, rd[7:0] & 8'hD1}, 32'h00000051);
		chk("window irq", {31'h0, irq}, 32'h1);
		wr(8'h04, 8'h00);
		partnerRaw <= 1'b0;
		clr;
	endtask

	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		compareRaw = 1'b0;
		partnerRaw = 1'b0;
		coreReadyRaw = 1'b0;
		sleepStandby = 1'b0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_fields;
		t_output;
		t_trigger;
		t_standby;
		t_window;
		end_sim;
	end

endmodule
